// File: verilog/drcd_defines.vh
/*
 Constants of the diagnosis command decoder: frame layout, command
 codes, reset values of the output controls.
 Assumes inclusion by bare name from the design files only.
*/
`ifndef DRCD_DEFINES_VH
`define DRCD_DEFINES_VH

// Frame: 16 bits MSB first, command field in the low 12 bits
`define DRCD_FRAME_W 16
`define DRCD_CMD_W 12
`define DRCD_BYTE_BITS 5'h08

// Full 12-bit commands without payload
`define DRCD_CMD_READ_A 12'h500
`define DRCD_CMD_READ_B 12'h600
`define DRCD_CMD_CLEAR_A 12'h100
`define DRCD_CMD_CLEAR_B 12'h200

// Upper nibble of commands carrying an output setting field
`define DRCD_OP_CLEAR_ALL 4'h8
`define DRCD_OP_SEL_ONE 4'hB
`define DRCD_OP_SEL_TWO 4'hD
`define DRCD_OP_SEL_THREE 4'hE

// Field positions of the output setting field
`define DRCD_OPS_SEL_LSB 0
`define DRCD_OPS_ON_LSB 4

// Decoded command kinds
`define DRCD_K_BAD 4'h0
`define DRCD_K_READ_A 4'h1
`define DRCD_K_READ_B 4'h2
`define DRCD_K_CLEAR_A 4'h3
`define DRCD_K_CLEAR_B 4'h4
`define DRCD_K_CLEAR_ALL 4'h5
`define DRCD_K_SELECT 4'h6

// Reset values: channels 7..10 on parallel pins, serial setting off
`define DRCD_RST_INPUT_SELECT 4'hF
`define DRCD_RST_SERIAL_ON 4'h0

`endif

// File: verilog/drcd_link.v
/*
 Serial link front end: synchronises chip select, serial clock and
 serial data to sys_clk, shifts in the frame and flags its events.
 Assumes the serial clock is far slower than sys_clk (at least
 eight sys_clk periods per serial clock period), idle low, data
 sampled on its rising edge.
*/
`include "drcd_defines.vh"
module drcd_link #(
   parameter FRAME_W = `DRCD_FRAME_W
) (
   input wire sys_clk,
   input wire reset,
   input wire spiClk,
   input wire spiCsN,
   input wire spiDataIn,
   output reg frameStart,
   output reg frameEnd,
   output reg frameOk,
   output reg byteDone,
   output reg shiftOut,
   output reg frameActive,
   output reg [FRAME_W-1:0] rxWord
);

   reg csMeta;
   reg csSync;
   reg csPrev;
   reg clkMeta;
   reg clkSync;
   reg clkPrev;
   reg dinMeta;
   reg dinSync;
   reg [4:0] bitCount;
   wire clkRise;
   wire clkFall;

   assign clkRise = clkSync & ~clkPrev;
   assign clkFall = ~clkSync & clkPrev;

   always @(posedge sys_clk) begin
      if (reset) begin
         csMeta <= 1'b1;
         csSync <= 1'b1;
         csPrev <= 1'b1;
         clkMeta <= 1'b0;
         clkSync <= 1'b0;
         clkPrev <= 1'b0;
         dinMeta <= 1'b0;
         dinSync <= 1'b0;
      end else begin
         csMeta <= spiCsN;
         csSync <= csMeta;
         csPrev <= csSync;
         clkMeta <= spiClk;
         clkSync <= clkMeta;
         clkPrev <= clkSync;
         dinMeta <= spiDataIn;
         dinSync <= dinMeta;
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         frameStart <= 1'b0;
         frameEnd <= 1'b0;
         frameOk <= 1'b0;
         byteDone <= 1'b0;
         shiftOut <= 1'b0;
         frameActive <= 1'b0;
         rxWord <= {FRAME_W{1'b0}};
         bitCount <= 5'h00;
      end else begin
         frameStart <= csPrev & ~csSync;
         frameEnd <= ~csPrev & csSync;
         frameOk <= (bitCount == FRAME_W[4:0]);
         byteDone <= 1'b0;
         shiftOut <= frameActive & clkFall;
         if (csPrev & ~csSync) begin
            frameActive <= 1'b1;
            bitCount <= 5'h00;
            rxWord <= {FRAME_W{1'b0}};
         end else if (~csPrev & csSync) begin
            frameActive <= 1'b0;
         end else if (frameActive & clkRise) begin
            rxWord <= {rxWord[FRAME_W-2:0], dinSync};
            // Saturate so that overlong frames never wrap to 16
            if (bitCount != 5'h1F)
               bitCount <= bitCount + 5'h01;
            byteDone <= (bitCount == `DRCD_BYTE_BITS - 5'h01);
         end
      end
   end

endmodule

// File: verilog/drcd_decoder.v
/*
 Diagnosis and compact output control command decoder, with its
 diagnosis banks, virtual diagnosis bits and channel 7..10 controls.
 Assumes a serial bus master framing 16-bit words with chip select,
 fault inputs from the diagnosis circuit, register 1..3 contents
 supplied from outside, pins asynchronous to sys_clk.
*/
`include "drcd_defines.vh"
module drcd_decoder #(
   parameter BANK_W = 12,
   parameter DR_W = 8
) (
   input wire sys_clk,
   input wire reset,
   input wire spiClk,
   input wire spiCsN,
   input wire spiDataIn,
   output reg spiDataOut,
   output wire spiDataOutEn,
   input wire [BANK_W-1:0] faultBankA,
   input wire [BANK_W-1:0] faultBankB,
   input wire [7:0] virtualDiagFault,
   input wire [DR_W-1:0] diagRegisterOne,
   input wire [DR_W-1:0] diagRegisterTwo,
   input wire [DR_W-1:0] diagRegisterThree,
   input wire [3:0] parallelInputPins,
   input wire commErrorClear,
   output reg [BANK_W-1:0] diagBankA,
   output reg [BANK_W-1:0] diagBankB,
   output reg [7:0] virtualDiagOut,
   output reg [3:0] inputSelect,
   output reg [3:0] serialOn,
   output reg [3:0] channelOut,
   output reg [1:0] selectedDiagRegister,
   output reg commError
);

   localparam FRAME_W = `DRCD_FRAME_W;

   wire frameStart;
   wire frameEnd;
   wire frameOk;
   wire byteDone;
   wire shiftOut;
   wire frameActive;
   wire [FRAME_W-1:0] rxWord;

   reg [3:0] pinMeta;
   reg [3:0] pinSync;
   reg [FRAME_W-1:0] txWord;
   reg [FRAME_W-1:0] pendingTx;
   reg pendingFeedback;
   reg [3:0] txIdx;

   reg [3:0] next_kind;
   reg next_clearA;
   reg next_clearB;
   reg next_clearVirtual;
   reg next_applyOps;
   reg next_badCmd;
   reg [FRAME_W-1:0] next_pendingTx;
   reg [7:0] opsField;
   reg [3:0] opNibble;

   // Full-field compare of the 12-bit command, upper nibble only for commands with a setting field
   function [3:0] cmdKind;
      input [`DRCD_CMD_W-1:0] f;
      begin
         case (f)
            `DRCD_CMD_READ_A: cmdKind = `DRCD_K_READ_A;
            `DRCD_CMD_READ_B: cmdKind = `DRCD_K_READ_B;
            `DRCD_CMD_CLEAR_A: cmdKind = `DRCD_K_CLEAR_A;
            `DRCD_CMD_CLEAR_B: cmdKind = `DRCD_K_CLEAR_B;
            default: begin
               case (f[11:8])
                  `DRCD_OP_CLEAR_ALL: cmdKind = `DRCD_K_CLEAR_ALL;
                  `DRCD_OP_SEL_ONE: cmdKind = `DRCD_K_SELECT;
                  `DRCD_OP_SEL_TWO: cmdKind = `DRCD_K_SELECT;
                  `DRCD_OP_SEL_THREE: cmdKind = `DRCD_K_SELECT;
                  default: cmdKind = `DRCD_K_BAD;
               endcase
            end
         endcase
      end
   endfunction

   drcd_link #(
      .FRAME_W(FRAME_W)
   ) link (
      .sys_clk(sys_clk),
      .reset(reset),
      .spiClk(spiClk),
      .spiCsN(spiCsN),
      .spiDataIn(spiDataIn),
      .frameStart(frameStart),
      .frameEnd(frameEnd),
      .frameOk(frameOk),
      .byteDone(byteDone),
      .shiftOut(shiftOut),
      .frameActive(frameActive),
      .rxWord(rxWord)
   );

   assign spiDataOutEn = frameActive;

   always @* begin
      next_kind = cmdKind(rxWord[`DRCD_CMD_W-1:0]);
      opNibble = rxWord[11:8];
      opsField = rxWord[7:0];
      next_clearA = 1'b0;
      next_clearB = 1'b0;
      next_clearVirtual = 1'b0;
      next_applyOps = 1'b0;
      next_badCmd = 1'b0;
      next_pendingTx = {FRAME_W{1'b0}};
      if (frameEnd) begin
         if (!frameOk) begin
            next_badCmd = 1'b1;
         end else begin
            case (next_kind)
               `DRCD_K_READ_A: begin
                  next_pendingTx[BANK_W-1:0] = diagBankA;
               end
               `DRCD_K_READ_B: begin
                  next_pendingTx[BANK_W-1:0] = diagBankB;
               end
               `DRCD_K_CLEAR_A: begin
                  next_pendingTx[BANK_W-1:0] = diagBankA;
                  next_clearA = 1'b1;
               end
               `DRCD_K_CLEAR_B: begin
                  next_pendingTx[BANK_W-1:0] = diagBankB;
                  next_clearB = 1'b1;
               end
               `DRCD_K_CLEAR_ALL: begin
                  next_clearA = 1'b1;
                  next_clearB = 1'b1;
                  next_clearVirtual = 1'b1;
                  next_applyOps = 1'b1;
               end
               `DRCD_K_SELECT: begin
                  next_applyOps = 1'b1;
               end
               default: begin
                  next_badCmd = 1'b1;
               end
            endcase
         end
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         pinMeta <= 4'h0;
         pinSync <= 4'h0;
         channelOut <= 4'h0;
      end else begin
         pinMeta <= parallelInputPins;
         pinSync <= pinMeta;
         // Parallel-selected channels follow their pins
         channelOut <= (inputSelect & pinSync)
            | (~inputSelect & serialOn);
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         diagBankA <= {BANK_W{1'b0}};
         diagBankB <= {BANK_W{1'b0}};
         virtualDiagOut <= 8'h00;
         inputSelect <= `DRCD_RST_INPUT_SELECT;
         serialOn <= `DRCD_RST_SERIAL_ON;
         selectedDiagRegister <= 2'h0;
         commError <= 1'b0;
         pendingTx <= {FRAME_W{1'b0}};
         pendingFeedback <= 1'b0;
      end else begin
         // Faults latch every cycle, so a persisting one survives a clear
         diagBankA <= (next_clearA ? {BANK_W{1'b0}} : diagBankA)
            | faultBankA;
         diagBankB <= (next_clearB ? {BANK_W{1'b0}} : diagBankB)
            | faultBankB;
         virtualDiagOut <= (next_clearVirtual ? 8'h00 : virtualDiagOut)
            | virtualDiagFault;
         if (next_applyOps) begin
            // Each bit is one option; a combination sets all of them
            inputSelect <= opsField[`DRCD_OPS_SEL_LSB +: 4];
            serialOn <= opsField[`DRCD_OPS_ON_LSB +: 4];
            case (opNibble)
               `DRCD_OP_SEL_ONE: selectedDiagRegister <= 2'h1;
               `DRCD_OP_SEL_TWO: selectedDiagRegister <= 2'h2;
               `DRCD_OP_SEL_THREE: selectedDiagRegister <= 2'h3;
               default: selectedDiagRegister <= selectedDiagRegister;
            endcase
         end
         // Set wins over a simultaneous clear
         if (next_badCmd)
            commError <= 1'b1;
         else if (commErrorClear)
            commError <= 1'b0;
         if (frameEnd) begin
            pendingTx <= next_pendingTx;
            pendingFeedback <= next_applyOps;
         end
      end
   end

   // Transmit word: loaded at frame start, second byte patched once the
   // upper command nibble is in, so the register the command selects (register two for clear-all) goes out now
   always @(posedge sys_clk) begin
      if (reset) begin
         txWord <= {FRAME_W{1'b0}};
         txIdx <= 4'h0;
         spiDataOut <= 1'b0;
      end else begin
         if (frameStart) begin
            txIdx <= 4'h0;
            if (pendingFeedback)
               txWord <= {4'h0, channelOut, 8'h00};
            else
               txWord <= pendingTx;
         end else begin
            if (shiftOut)
               txIdx <= txIdx + 4'h1;
            if (byteDone) begin
               case (rxWord[3:0])
                  `DRCD_OP_CLEAR_ALL:
                     txWord[7:0] <= diagRegisterTwo;
                  `DRCD_OP_SEL_ONE:
                     txWord[7:0] <= diagRegisterOne;
                  `DRCD_OP_SEL_TWO:
                     txWord[7:0] <= diagRegisterTwo;
                  `DRCD_OP_SEL_THREE:
                     txWord[7:0] <= diagRegisterThree;
                  default:
                     txWord[7:0] <= txWord[7:0];
               endcase
            end
         end
         spiDataOut <= frameActive ? txWord[~txIdx] : 1'b0;
      end
   end

endmodule

// File: verif/drcd_monitor.sv
/*
 Checker of the diagnosis command decoder port behaviour.
 Assumes binding to drcd_decoder; sees its ports only.
*/
module drcd_monitor #(
   parameter BANK_W = 12
) (
   input wire sys_clk,
   input wire reset,
   input wire spiCsN,
   input wire spiDataOutEn,
   input wire [BANK_W-1:0] faultBankA,
   input wire [BANK_W-1:0] diagBankA,
   input wire [3:0] parallelInputPins,
   input wire commErrorClear,
   input wire [3:0] inputSelect,
   input wire [3:0] serialOn,
   input wire [3:0] channelOut,
   input wire [1:0] selectedDiagRegister,
   input wire commError
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_idle; spiCsN[*8]; endsequence
   sequence s_en_soon; ##[2:8] spiDataOutEn; endsequence
   sequence s_pins_steady;
      ($stable(parallelInputPins) && $stable(inputSelect))[*6];
   endsequence
   property p_reset_values;
      $past(reset) |-> inputSelect == 4'hF && serialOn == 4'h0 &&
         selectedDiagRegister == 2'h0 && !commError;
   endproperty
   property p_idle; s_idle |-> !spiDataOutEn; endproperty
   property p_open; $fell(spiCsN) |-> s_en_soon; endproperty
   property p_fault_kept;
      !$past(reset) |-> ($past(faultBankA) & ~diagBankA) == 0;
   endproperty
   property p_clear_at_end;
      ($past(diagBankA) & ~diagBankA) != 0 |-> spiCsN && $past(spiCsN, 2);
   endproperty
   property p_set_at_end;
      !$stable({inputSelect, serialOn, selectedDiagRegister}) |->
         spiCsN && $past(spiCsN, 2);
   endproperty
   property p_serial_drive;
      !$past(reset) |->
         ((channelOut ^ $past(serialOn)) & ~$past(inputSelect)) == 4'h0;
   endproperty
   property p_parallel_drive;
      s_pins_steady |-> ((channelOut ^ parallelInputPins) & inputSelect) == 0;
   endproperty
   property p_err_clear;
      $fell(commError) |-> $past(commErrorClear);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("control outputs wrong after reset");
   a_idle: assert property (p_idle)
      else $error("output enabled outside a frame");
   a_open: assert property (p_open)
      else $error("output not enabled after frame start");
   a_fault_kept: assert property (p_fault_kept)
      else $error("present fault missing from bank A");
   a_clear_at_end: assert property (p_clear_at_end)
      else $error("bank A bit cleared inside a frame");
   a_set_at_end: assert property (p_set_at_end)
      else $error("settings changed inside a frame");
   a_serial_drive: assert property (p_serial_drive)
      else $error("serial channel drive wrong");
   a_parallel_drive: assert property (p_parallel_drive)
      else $error("parallel channel drive wrong");
   a_err_clear: assert property (p_err_clear)
      else $error("error flag dropped without clear");
endmodule

// File: verif/drcd_master.sv
/*
 Serial bus master model sending 16-bit frames MSB first.
 Assumes sys_clk as time base; serial clock period is 12 sys_clk.
*/
module drcd_master (
   input wire sys_clk,
   output logic spiClk,
   output logic spiCsN,
   output logic spiDataIn,
   input wire spiDataOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rx;
   event done;
   initial begin
      spiClk = 1'b0;
      spiCsN = 1'b1;
      spiDataIn = 1'b0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Clock rests low between frames; released data shows its inverse
   // A last bit index above zero cuts the frame short
   task automatic xfer(input logic [15:0] w, input int gap,
      input int last = 0);
      rx = 16'h0000;
      spiCsN = 1'b0;
      wait_n(12);
      for (int i = 15; i >= last; i--) begin
         spiDataIn = w[i];
         wait_n(6);
         spiClk = 1'b1;
         rx[i] = spiDataOut;
         wait_n(6);
         spiClk = 1'b0;
      end
      spiDataIn = ~spiDataIn;
      wait_n(6);
      spiCsN = 1'b1;
      ->done;
      wait_n(gap);
   endtask
endmodule

// File: verif/test_drcd_decoder.sv
/*
 Self-checking bench of the diagnosis command decoder.
 Assumes the decoder, its checker and the serial master model.
*/
module test_drcd_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic errClear = 1'b0;
   wire spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn, commError;
   logic [11:0] faultBankA = 12'h000, faultBankB = 12'h000, r;
   logic [7:0] vFault = 8'h00, regOne, regTwo, regThree, op;
   logic [3:0] pins, chOut;
   logic [3:0] codes [4] = '{4'hB, 4'hD, 4'hE, 4'h8};
   logic [1:0] sels [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
   wire [11:0] diagBankA, diagBankB;
   wire [7:0] virtualDiagOut;
   wire [3:0] inputSelect, serialOn, channelOut;
   wire [1:0] selectedDiagRegister;
   logic [15:0] expQ [$];
   logic [15:0] nextRep = 16'h0000;
   int miscompares = 0, checked = 0, cycles = 0;
   always #2 sys_clk = ~sys_clk;
   drcd_decoder uut (.sys_clk(sys_clk), .reset(reset), .spiClk(spiClk),
      .spiCsN(spiCsN), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
      .spiDataOutEn(spiDataOutEn), .faultBankA(faultBankA),
      .faultBankB(faultBankB), .virtualDiagFault(vFault),
      .diagRegisterOne(regOne), .diagRegisterTwo(regTwo),
      .diagRegisterThree(regThree), .parallelInputPins(pins),
      .commErrorClear(errClear), .diagBankA(diagBankA),
      .diagBankB(diagBankB), .virtualDiagOut(virtualDiagOut),
      .inputSelect(inputSelect), .serialOn(serialOn),
      .channelOut(channelOut), .selectedDiagRegister(selectedDiagRegister),
      .commError(commError));
   drcd_master m (.sys_clk(sys_clk), .spiClk(spiClk), .spiCsN(spiCsN),
      .spiDataIn(spiDataIn), .spiDataOut(spiDataOut));
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Queues this frame's reply, then runs the frame
   task automatic send(input logic [15:0] w, input logic [15:0] nxt);
      logic [15:0] now;
      now = nextRep;
      case (w[11:8])
         4'h8, 4'hD: now[7:0] = regTwo;
         4'hB: now[7:0] = regOne;
         4'hE: now[7:0] = regThree;
         default: ;
      endcase
      expQ.push_back(now);
      nextRep = nxt;
      m.xfer(w, $urandom_range(40, 10));
   endtask
   initial forever begin
      @(m.done);
      check(m.rx, expQ.pop_front());
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      void'($urandom(79));
      pins = $urandom;
      regOne = $urandom;
      regTwo = $urandom;
      regThree = $urandom;
      r = $urandom;
      repeat (3) @(negedge sys_clk);
      reset = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(inputSelect, 4'hF);
      faultBankA = r;
      faultBankB = ~r;
      @(negedge sys_clk);
      faultBankA = 12'h004;
      faultBankB = 12'h000;
      send(16'h0500, {4'h0, r | 12'h004});
      send(16'h0500, {4'h0, r | 12'h004});
      send(16'h0100, {4'h0, r | 12'h004});
      check(diagBankA, 12'h004);
      send(16'h0600, {4'h0, ~r});
      send(16'h0200, {4'h0, ~r});
      check(diagBankB, 12'h000);
      faultBankB = r;
      vFault = $urandom;
      @(negedge sys_clk);
      faultBankB = 12'h000;
      vFault = 8'h00;
      for (int i = 0; i < 9; i++) begin
         op = (i < 8) ? 8'h01 << i : 8'($urandom);
         chOut = (op[3:0] & pins) | (~op[3:0] & op[7:4]);
         send({4'h0, codes[i % 4], op}, {4'h0, chOut, 8'h00});
         check({serialOn, inputSelect}, op);
         check(channelOut, chOut);
         check(selectedDiagRegister, sels[i % 4]);
         if (codes[i % 4] == 4'h8) begin
            check(virtualDiagOut, 8'h00);
            check(diagBankA, 12'h004);
            check(diagBankB, 12'h000);
         end
      end
      send(16'h0501, 16'h0000);
      check({commError, serialOn, inputSelect}, {1'b1, op});
      errClear = 1'b1;
      @(negedge sys_clk);
      errClear = 1'b0;
      @(negedge sys_clk);
      check(commError, 1'b0);
      // Fifteen-bit frame: refused, flagged, next reply stays zero
      expQ.push_back(16'h0000);
      m.xfer(16'h0500, 12, 1);
      check(commError, 1'b1);
      check({serialOn, inputSelect}, op);
      send(16'h0500, 16'h0004);
      close_out();
   end
endmodule
bind drcd_decoder drcd_monitor #(.BANK_W(BANK_W)) u_mon (.sys_clk(sys_clk),
   .reset(reset), .spiCsN(spiCsN), .spiDataOutEn(spiDataOutEn),
   .faultBankA(faultBankA), .diagBankA(diagBankA),
   .parallelInputPins(parallelInputPins), .commErrorClear(commErrorClear),
   .inputSelect(inputSelect), .serialOn(serialOn), .channelOut(channelOut),
   .selectedDiagRegister(selectedDiagRegister), .commError(commError));
